// ===== sar_adc_pkg.sv
// sar_adc_pkg.sv - constants and types shared by the converter sequencer files
// assumes: included before every module of the sequencer; nothing imported
package sar_adc_pkg;
  localparam int RES_W = 8;                       // result width in bits
  localparam int CONV_PERIODS = 10;               // bit periods per conversion
  localparam logic [3:0] CYC_W = 4'h4;            // width of period counter
  // register offsets on the plain port
  localparam logic [2:0] OFF_CTRL_A = 3'h0;       // channel, go/done, on bit
  localparam logic [2:0] OFF_CTRL_B = 3'h1;       // clock select, reference
  localparam logic [2:0] OFF_RESULT = 3'h2;       // conversion result
  localparam logic [2:0] OFF_FLAGS = 3'h3;        // done flag, enables
  // field positions in control register a
  localparam int CA_ON = 0;
  localparam int CA_GO = 1;
  localparam int CA_CHS_LO = 2;
  // field positions in control register b
  localparam int CB_REF_LO = 0;
  localparam int CB_CS_LO = 4;
  // field positions in the flags register
  localparam int FL_DONE = 0;
  localparam int FL_IRQ_EN = 1;
  localparam int FL_PERI_EN = 2;
  localparam int FL_GLOB_EN = 3;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  // channel codes
  localparam logic [3:0] CHS_LAST_PIN = 4'hA;
  localparam logic [3:0] CHS_FIXED_REF = 4'hF;
  // reference codes
  localparam logic [1:0] REF_EXT = 2'h2;
  localparam logic [1:0] REF_FIXED = 2'h3;
  // timing: sleep delay of one instruction cycle, four system clocks each
  localparam int INSTR_NS = 20;
  localparam int CLK_NS = 5;
  localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;
  typedef enum logic [1:0] {
    REFSEL_SUPPLY = 2'b00,
    REFSEL_EXT_PIN = 2'b01,
    REFSEL_FIXED = 2'b10
  } ref_sel_t;
endpackage

// ===== sar_tick_if.sv
// sar_tick_if.sv - carries the bit period tick from the divider to the sequencer
// assumes: both ends on the same system clock
`timescale 1ns/1ps
interface sar_tick_if;
  logic [2:0] clk_sel;   // conversion clock select code
  logic run;             // divider runs while high
  logic tick;            // one-cycle pulse per bit period
  modport src (input clk_sel, input run, output tick);
  modport dst (output clk_sel, output run, input tick);
endinterface

// ===== sar_clk_div.sv
// sar_clk_div.sv - bit period tick generator from system clock or rc clock
// assumes: rc clock arrives asynchronously and is synchronised here
`timescale 1ns/1ps
module sar_clk_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rc_clk,
  sar_tick_if.src tk
);
  logic [5:0] cnt_q;       // system clock divider
  logic [5:0] limit;       // divide ratio minus one
  logic rc_s1_q;           // first sync stage only
  logic rc_s2_q;
  logic rc_s3_q;           // edge detect stage
  logic rc_mode;
  logic tick_q;
  assign rc_mode = (tk.clk_sel[1:0] == 2'b11);  // any x11 code [RULE_04]
  // divide ratio decode [RULE_04]
  always_comb begin
    case (tk.clk_sel)
      3'b000: limit = 6'h01;
      3'b100: limit = 6'h03;
      3'b001: limit = 6'h07;
      3'b101: limit = 6'h0F;
      3'b010: limit = 6'h1F;
      3'b110: limit = 6'h3F;
      default: limit = 6'h00;
    endcase
  end
  // rc clock synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end else begin
      rc_s1_q <= i_rc_clk;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end
  // tick generation; counter held clear while stopped so every divided-clock run starts aligned
  always_ff @(posedge i_clk) begin
    if (i_rst || !tk.run) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (rc_mode) begin
      cnt_q <= 6'h00;
      tick_q <= rc_s2_q && !rc_s3_q;
    end else if (cnt_q == limit) begin
      cnt_q <= 6'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      tick_q <= 1'b0;
    end
  end
  assign tk.tick = tick_q;
endmodule

// ===== sar_sar_core.sv
// sar_sar_core.sv - successive approximation register with partial result fill
// assumes: comparator sampled on each step by the caller
`timescale 1ns/1ps
module sar_sar_core #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic i_step,
  input wire logic i_cmp,
  output logic [W-1:0] o_code,
  output logic [W-1:0] o_partial
);
  logic [W-1:0] code_q;    // trial code
  logic [W-1:0] mask_q;    // one-hot bit under trial
  logic last_q;            // last bit resolved
  logic [W-1:0] done_m;    // bits already resolved
  // successive approximation step [RULE_01]
  always_ff @(posedge i_clk) begin
    if (i_rst || i_load) begin
      code_q <= {1'b1, {(W-1){1'b0}}};
      mask_q <= {1'b1, {(W-1){1'b0}}};
      last_q <= 1'b0;
    end else if (i_step && mask_q != '0) begin
      code_q <= (i_cmp ? code_q : (code_q & ~mask_q)) | (mask_q >> 1);
      mask_q <= mask_q >> 1;
      last_q <= i_cmp;
    end
  end
  // resolved bits are those above the trial bit
  always_comb begin
    done_m = ~((mask_q << 1) - {{(W-1){1'b0}}, 1'b1});
    if (mask_q == '0) begin
      done_m = '1;
    end
  end
  assign o_code = code_q;
  // unresolved bits copy the last resolved bit [RULE_13]
  assign o_partial = (code_q & done_m) | ({W{last_q}} & ~done_m);
endmodule

// ===== sar_adc_sequencer.sv
// sar_adc_sequencer.sv - control and sequencing of an 8-bit sar converter
// assumes: comparator output and rc clock are asynchronous pins
// Summary of operation
// RULE_01 - eight-bit successive approximation into result register
// RULE_02 - channel field routes input to sample-hold
// RULE_03 - reference field picks positive reference, ground negative
// RULE_04 - clock field picks divider or rc clock
// RULE_05 - conversion lasts exactly ten bit periods
// RULE_06 - done flag set after every conversion
// RULE_07 - hardware never clears the done flag
// RULE_08 - enabled completion raises interrupt, wakes from sleep
// RULE_09 - after wake, vector only if both enables
// RULE_10 - on bit enables, go write starts conversion
// RULE_11 - software turns on before setting go
// RULE_12 - completion clears go, sets flag, loads result
// RULE_13 - abort stores partial result, fill last bit
// RULE_14 - reset clears registers and aborts conversion
// RULE_15 - sleep conversion only on rc, one-instruction delay
// RULE_16 - sleep rc no irq powers down after
// RULE_17 - sleep non-rc aborts and powers down
// RULE_18 - special event sets go, resets timer
// RULE_19 - software keeps timing under special trigger
// RULE_20 - above 1 MHz use rc only in sleep
// RULE_21 - channel codes 0-10 pins, 15 fixed reference
// RULE_22 - reference codes 0x supply, 10 pin, 11 fixed
// RULE_23 - go reads one while converting
// RULE_24 - result holds through conversion until end
// RULE_25 - go without on bit does nothing
`timescale 1ns/1ps
module sar_adc_sequencer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rc_clk,
  input wire logic i_cmp,
  input wire logic i_sleep,
  input wire logic i_special_evt,
  output logic o_timer_clear,
  output logic [3:0] o_chan_sel,
  output logic o_chan_fixed_ref,
  output logic [1:0] o_ref_sel,
  output logic [7:0] o_dac_code,
  output logic o_analog_on,
  output logic o_irq,
  output logic o_wake,
  output logic o_vector
);
  sar_tick_if tk ();
  sar_adc_pkg::seq_state_t st_q;   // sequencer state
  logic [7:0] ctrl_a_q;            // channel, go, on
  logic [7:0] ctrl_b_q;            // clock select, reference
  logic [7:0] result_q;            // result register
  logic done_flag_q;               // sticky completion flag
  logic irq_en_q;
  logic peri_en_q;
  logic glob_en_q;
  logic [3:0] per_q;               // bit periods elapsed
  logic [3:0] dly_q;               // sleep start delay count
  logic cmp_s1_q;                  // comparator sync, first stage
  logic cmp_s2_q;
  logic evt_s1_q;                  // special event sync, first stage
  logic evt_s2_q;
  logic evt_s3_q;
  logic slp_s1_q;                  // sleep sync, first stage
  logic slp_s2_q;
  logic powered_down_q;            // module off though on bit stays
  logic evt_pulse;
  logic rc_mode;
  logic go_wr1;
  logic go_wr0;
  logic finish;
  logic abort_sw;
  logic abort_sleep;
  logic sar_load;
  logic sar_step;
  logic [7:0] code;
  logic [7:0] partial;
  logic start_req;
  logic [7:0] rdata_d;
  // any clock code ending in 11 runs from the rc clock, which keeps going in sleep [RULE_04]
  assign rc_mode = ctrl_b_q[sar_adc_pkg::CB_CS_LO +: 2] == 2'b11;
  // synchronisers for pin inputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      evt_s1_q <= 1'b0;
      evt_s2_q <= 1'b0;
      evt_s3_q <= 1'b0;
      slp_s1_q <= 1'b0;
      slp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= i_cmp;
      cmp_s2_q <= cmp_s1_q;
      evt_s1_q <= i_special_evt;
      evt_s2_q <= evt_s1_q;
      evt_s3_q <= evt_s2_q;
      slp_s1_q <= i_sleep;
      slp_s2_q <= slp_s1_q;
    end
  end
  assign evt_pulse = evt_s2_q && !evt_s3_q;
  // decoded requests
  assign go_wr1 = i_wr && i_addr == sar_adc_pkg::OFF_CTRL_A && i_wdata[sar_adc_pkg::CA_GO];
  assign go_wr0 = i_wr && i_addr == sar_adc_pkg::OFF_CTRL_A && !i_wdata[sar_adc_pkg::CA_GO];
  // go needs the on bit as already stored [RULE_10] [RULE_25]
  assign start_req = (go_wr1 || evt_pulse) && ctrl_a_q[sar_adc_pkg::CA_ON] && st_q == sar_adc_pkg::ST_IDLE;
  assign finish = st_q == sar_adc_pkg::ST_CONV && tk.tick && per_q == 4'(sar_adc_pkg::CONV_PERIODS - 1); // [RULE_05]
  assign abort_sw = st_q != sar_adc_pkg::ST_IDLE && go_wr0 && !finish; // [RULE_13]
  assign abort_sleep = st_q != sar_adc_pkg::ST_IDLE && slp_s2_q && !rc_mode; // [RULE_17]
  assign sar_load = st_q != sar_adc_pkg::ST_CONV;
  // periods 1..8 resolve the eight bits, period 0 samples, period 9 settles
  assign sar_step = st_q == sar_adc_pkg::ST_CONV && tk.tick && per_q != 4'h0 && per_q != 4'h9;
  assign tk.clk_sel = ctrl_b_q[sar_adc_pkg::CB_CS_LO +: 3];
  assign tk.run = st_q == sar_adc_pkg::ST_CONV;
  sar_clk_div u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rc_clk(i_rc_clk),
    .tk(tk.src)
  );
  sar_sar_core #(.W(sar_adc_pkg::RES_W)) u_core (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(sar_load),
    .i_step(sar_step),
    .i_cmp(cmp_s2_q),
    .o_code(code),
    .o_partial(partial)
  );
  // sequencer; sleep delay only with rc clock [RULE_15]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= sar_adc_pkg::ST_IDLE; // [RULE_14]
      per_q <= 4'h0;
      dly_q <= 4'h0;
    end else begin
      case (st_q)
        sar_adc_pkg::ST_IDLE: begin
          per_q <= 4'h0;
          dly_q <= 4'h0;
          if (start_req) begin
            st_q <= (ctrl_b_q[sar_adc_pkg::CB_CS_LO +: 2] == 2'b11) ? sar_adc_pkg::ST_DELAY : sar_adc_pkg::ST_CONV;
          end
        end
        sar_adc_pkg::ST_DELAY: begin
          if (abort_sw || abort_sleep) begin
            st_q <= sar_adc_pkg::ST_IDLE;
          end else if (dly_q == 4'(sar_adc_pkg::INSTR_CYC - 1)) begin
            st_q <= sar_adc_pkg::ST_CONV;
          end else begin
            dly_q <= dly_q + 4'h1;
          end
        end
        sar_adc_pkg::ST_CONV: begin
          if (finish || abort_sw || abort_sleep) begin
            st_q <= sar_adc_pkg::ST_IDLE;
          end else if (tk.tick) begin
            per_q <= per_q + 4'h1;
          end
        end
        default: st_q <= sar_adc_pkg::ST_IDLE;
      endcase
    end
  end
  // control register a; go mirrors activity [RULE_23]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_a_q <= sar_adc_pkg::CTRL_A_RST; // [RULE_14]
    end else begin
      if (i_wr && i_addr == sar_adc_pkg::OFF_CTRL_A) begin
        ctrl_a_q <= {2'b00, i_wdata[5:2], 1'b0, i_wdata[sar_adc_pkg::CA_ON]};
      end
      if (start_req) begin
        ctrl_a_q[sar_adc_pkg::CA_GO] <= 1'b1; // [RULE_18]
      end else if (finish || abort_sleep) begin
        ctrl_a_q[sar_adc_pkg::CA_GO] <= 1'b0; // [RULE_12]
      end else if (i_wr && i_addr == sar_adc_pkg::OFF_CTRL_A) begin
        ctrl_a_q[sar_adc_pkg::CA_GO] <= i_wdata[sar_adc_pkg::CA_GO] && st_q != sar_adc_pkg::ST_IDLE;
      end
    end
  end
  // control register b
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_b_q <= sar_adc_pkg::CTRL_B_RST;
    end else if (i_wr && i_addr == sar_adc_pkg::OFF_CTRL_B) begin
      ctrl_b_q <= {1'b0, i_wdata[6:4], 2'b00, i_wdata[1:0]};
    end
  end
  // result holds until completion, software abort or write; a sleep abort leaves it unchanged [RULE_24]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_q <= sar_adc_pkg::RESULT_RST;
    end else if (finish) begin
      result_q <= code; // [RULE_01] [RULE_12]
    end else if (abort_sw) begin
      result_q <= partial; // [RULE_13]
    end else if (i_wr && i_addr == sar_adc_pkg::OFF_RESULT) begin
      result_q <= i_wdata;
    end
  end
  // done flag: set wins, only software clears [RULE_06] [RULE_07]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      peri_en_q <= 1'b0;
      glob_en_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == sar_adc_pkg::OFF_FLAGS) begin
        done_flag_q <= i_wdata[sar_adc_pkg::FL_DONE];
        irq_en_q <= i_wdata[sar_adc_pkg::FL_IRQ_EN];
        peri_en_q <= i_wdata[sar_adc_pkg::FL_PERI_EN];
        glob_en_q <= i_wdata[sar_adc_pkg::FL_GLOB_EN];
      end
      if (finish) begin
        done_flag_q <= 1'b1;
      end
    end
  end
  // power state; on bit untouched [RULE_16] [RULE_17]
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      powered_down_q <= 1'b0;
    end else if (!slp_s2_q || start_req) begin
      // a new start in sleep powers the analog side up again
      powered_down_q <= 1'b0;
    end else if (abort_sleep || (st_q == sar_adc_pkg::ST_IDLE && !start_req && !irq_en_q)) begin
      powered_down_q <= 1'b1;
    end
  end
  // read mux, data one cycle later; unmapped reads zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == sar_adc_pkg::OFF_CTRL_A) begin
      rdata_d = ctrl_a_q;
    end else if (i_addr == sar_adc_pkg::OFF_CTRL_B) begin
      rdata_d = ctrl_b_q;
    end else if (i_addr == sar_adc_pkg::OFF_RESULT) begin
      rdata_d = result_q;
    end else if (i_addr == sar_adc_pkg::OFF_FLAGS) begin
      rdata_d = {4'h0, glob_en_q, peri_en_q, irq_en_q, done_flag_q};
    end
  end
  // registered outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_timer_clear <= 1'b0;
      o_chan_sel <= 4'h0;
      o_chan_fixed_ref <= 1'b0;
      o_ref_sel <= sar_adc_pkg::REFSEL_SUPPLY;
      o_dac_code <= 8'h00;
      o_analog_on <= 1'b0;
      o_irq <= 1'b0;
      o_wake <= 1'b0;
      o_vector <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rdata_d : 8'h00;
      o_timer_clear <= evt_pulse; // [RULE_18]
      // reserved channel codes select channel 0 [RULE_02] [RULE_21]
      o_chan_sel <= (ctrl_a_q[5:2] <= sar_adc_pkg::CHS_LAST_PIN) ? ctrl_a_q[5:2] : 4'h0;
      o_chan_fixed_ref <= ctrl_a_q[5:2] == sar_adc_pkg::CHS_FIXED_REF;
      // negative reference is ground by construction [RULE_03] [RULE_22]
      if (ctrl_b_q[1:0] == sar_adc_pkg::REF_FIXED) begin
        o_ref_sel <= sar_adc_pkg::REFSEL_FIXED;
      end else if (ctrl_b_q[1:0] == sar_adc_pkg::REF_EXT) begin
        o_ref_sel <= sar_adc_pkg::REFSEL_EXT_PIN;
      end else begin
        o_ref_sel <= sar_adc_pkg::REFSEL_SUPPLY;
      end
      o_dac_code <= code;
      o_analog_on <= ctrl_a_q[sar_adc_pkg::CA_ON] && !powered_down_q;
      o_irq <= done_flag_q && irq_en_q; // [RULE_08]
      o_wake <= done_flag_q && irq_en_q && slp_s2_q; // [RULE_08]
      o_vector <= done_flag_q && irq_en_q && peri_en_q && glob_en_q; // [RULE_09]
    end
  end
  // assertions
  a_done_sets_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    finish |=> done_flag_q && !ctrl_a_q[sar_adc_pkg::CA_GO]) // [RULE_06]
    else $error("done flag or go not updated at completion");
  a_flag_not_hw_clr: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(done_flag_q) && !$past(i_rst) |-> $past(i_wr) && $past(i_addr) == sar_adc_pkg::OFF_FLAGS) // [RULE_07]
    else $error("done flag cleared without software write");
  a_no_start_off: assert property (@(posedge i_clk) disable iff (i_rst)
    go_wr1 && !ctrl_a_q[sar_adc_pkg::CA_ON] && st_q == sar_adc_pkg::ST_IDLE && !evt_pulse
    |=> st_q == sar_adc_pkg::ST_IDLE && !ctrl_a_q[sar_adc_pkg::CA_GO]) // [RULE_25]
    else $error("conversion started while off");
  a_result_holds: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst && !finish && !abort_sw && !(i_wr && i_addr == sar_adc_pkg::OFF_RESULT) |=> $stable(result_q)) // [RULE_24]
    else $error("result changed outside completion");
  a_result_loaded: assert property (@(posedge i_clk) disable iff (i_rst)
    finish |=> result_q == $past(code)) // [RULE_12]
    else $error("result not loaded at completion");
  a_go_busy: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q == sar_adc_pkg::ST_CONV |-> ctrl_a_q[sar_adc_pkg::CA_GO]) // [RULE_23]
    else $error("go low during conversion");
  a_sleep_abort: assert property (@(posedge i_clk) disable iff (i_rst)
    abort_sleep |=> st_q == sar_adc_pkg::ST_IDLE && powered_down_q && ctrl_a_q[sar_adc_pkg::CA_ON]) // [RULE_17]
    else $error("sleep did not abort non-rc conversion");
  a_evt_timer_clr: assert property (@(posedge i_clk) disable iff (i_rst)
    evt_pulse |=> o_timer_clear) // [RULE_18]
    else $error("timer clear missing after special event");
  a_irq_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    finish && irq_en_q && !(i_wr && i_addr == sar_adc_pkg::OFF_FLAGS) |-> ##3 o_irq) // [RULE_08]
    else $error("interrupt not raised after completion");
endmodule

// ===== sar_adc_sequencer_tb_top.sv
// sar_adc_sequencer_tb_top.sv - self-checking bench for the converter sequencer
// assumes: sar_adc_pkg and the design files are compiled first; bench drives every pin
`timescale 1ns/1ps
module sar_adc_sequencer_tb_top;
  localparam int LIMIT = 20000; // cycle ceiling, the whole run needs about 4000
  logic i_clk = 1'b0; // 200 MHz system clock
  logic i_rst = 1'b1; // sync reset, held 4 cycles
  logic [2:0] i_addr = 3'h0; // register port
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_rc_clk = 1'b0; // free-running rc oscillator, 16 system cycles a period
  logic i_cmp = 1'b0; // comparator model output
  logic i_sleep = 1'b0;
  logic i_special_evt = 1'b0;
  logic [7:0] o_rdata;
  logic [7:0] o_dac_code;
  logic [3:0] o_chan_sel;
  logic [1:0] o_ref_sel;
  logic o_timer_clear, o_chan_fixed_ref, o_analog_on, o_irq, o_wake, o_vector;
  logic [7:0] vin = 8'h5A; // analog input, half an lsb above this code
  int cyc = 0; // cycle counter for lengths and timeout
  int fails = 0;
  int tests_run = 0;

  sar_adc_sequencer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rc_clk(i_rc_clk), .i_cmp(i_cmp),
    .i_sleep(i_sleep), .i_special_evt(i_special_evt), .o_timer_clear(o_timer_clear),
    .o_chan_sel(o_chan_sel), .o_chan_fixed_ref(o_chan_fixed_ref), .o_ref_sel(o_ref_sel),
    .o_dac_code(o_dac_code), .o_analog_on(o_analog_on), .o_irq(o_irq), .o_wake(o_wake),
    .o_vector(o_vector));

  // clocks: rc edges coincide with system clock falling edges, fixed in phase
  always #2.5 i_clk = ~i_clk;
  always #40 i_rc_clk = ~i_rc_clk;

  // comparator: input at or above the trial code keeps the bit, never ambiguous
  always @(posedge i_clk) i_cmp <= (vin >= o_dac_code);

  // cycle count and hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one-cycle write strobe; a gap cycle follows before the next access
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, msg);
  endtask

  // poll the go bit with a bounded count, return cycles spent
  task automatic wait_done(output int n);
    int t0;
    logic [7:0] d;
    t0 = cyc;
    d = 8'h02;
    for (int k = 0; k < 400 && d[1] !== 1'b0; k++) rd(sar_adc_pkg::OFF_CTRL_A, d);
    n = cyc - t0;
  endtask

  task automatic done_test(input string s);
    $display("test %s finished", s);
  endtask

  // divider length per clock code, rc counted as its period in system cycles
  function automatic int per(input logic [2:0] cs);
    if (cs[1:0] == 2'b11) return 16;
    return 2 << (2 * cs[1:0] + cs[2]);
  endfunction

  initial begin
    int n;
    logic [7:0] d;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, address 4 is unmapped
    for (int a = 0; a < 5; a++) chk_rd(3'(a), 8'h00, "reset value");
    done_test("reset");
    // go refused while off and in the write that turns the converter on
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h02);
    chk_rd(sar_adc_pkg::OFF_CTRL_A, 8'h00, "go while off");
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    chk_rd(sar_adc_pkg::OFF_CTRL_A, 8'h01, "go with on");
    done_test("go refused");
    // every channel code, reserved ones select channel 0
    for (int c = 0; c < 16; c++) begin
      wr(sar_adc_pkg::OFF_CTRL_A, {2'h0, 4'(c), 2'h1});
      @(posedge i_clk);
      #1 chk({4'h0, o_chan_sel}, (c <= 10) ? 8'(c) : 8'h00, "channel");
      chk({7'h0, o_chan_fixed_ref}, {7'h0, c == 15}, "fixed channel");
      chk_rd(sar_adc_pkg::OFF_CTRL_A, {2'h0, 4'(c), 2'h1}, "channel readback");
    end
    // every reference code
    for (int r = 0; r < 4; r++) begin
      wr(sar_adc_pkg::OFF_CTRL_B, 8'h60 | 8'(r));
      @(posedge i_clk);
      #1 chk({6'h0, o_ref_sel}, (r < 2) ? 8'h00 : 8'(r - 1), "reference");
    end
    done_test("routing");
    // every clock code: ten periods per conversion; on first, go later
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h01);
    for (int cs = 0; cs < 8; cs++) begin
      wr(sar_adc_pkg::OFF_CTRL_B, {1'b0, 3'(cs), 4'h0});
      wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
      wait_done(n);
      // free-running rc clock: the first period may be partial
      chk({7'h0, n >= 10 * per(3'(cs)) - ((cs % 4 == 3) ? 16 : 2) && n <= 10 * per(3'(cs)) + ((cs % 4 == 3) ? 30 : 12)},
        8'h01, "conversion length");
    end
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h01, "flag without enable");
    chk({7'h0, o_irq}, 8'h00, "irq while disabled");
    done_test("clock codes");
    // full conversion; result held until the end, flag kept by hardware
    wr(sar_adc_pkg::OFF_CTRL_B, 8'h60);
    wr(sar_adc_pkg::OFF_RESULT, 8'h33);
    wr(sar_adc_pkg::OFF_FLAGS, 8'h00);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    repeat (300) @(posedge i_clk);
    chk_rd(sar_adc_pkg::OFF_RESULT, 8'h33, "result held");
    chk_rd(sar_adc_pkg::OFF_CTRL_A, 8'h03, "go while busy");
    wait_done(n);
    chk_rd(sar_adc_pkg::OFF_RESULT, 8'h5A, "result");
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h01, "done flag");
    repeat (50) @(posedge i_clk);
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h01, "flag kept");
    done_test("conversion");
    // abort after four resolved bits: 0101 then filled with the last one
    wr(sar_adc_pkg::OFF_FLAGS, 8'h00);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    repeat (64 * 5 + 30) @(posedge i_clk);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h01);
    chk_rd(sar_adc_pkg::OFF_RESULT, 8'h5F, "partial result");
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h00, "no flag on abort");
    done_test("abort");
    // interrupt then vector only with both enables
    wr(sar_adc_pkg::OFF_FLAGS, 8'h02);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    wait_done(n);
    repeat (3) @(posedge i_clk);
    #1 chk({7'h0, o_irq}, 8'h01, "irq");
    chk({7'h0, o_vector}, 8'h00, "vector without enables");
    wr(sar_adc_pkg::OFF_FLAGS, 8'h0F);
    repeat (2) @(posedge i_clk);
    #1 chk({7'h0, o_vector}, 8'h01, "vector");
    wr(sar_adc_pkg::OFF_FLAGS, 8'h0E);
    repeat (2) @(posedge i_clk);
    #1 chk({7'h0, o_irq}, 8'h00, "flag cleared by software");
    done_test("interrupt");
    // special event on the fastest clock
    wr(sar_adc_pkg::OFF_CTRL_B, 8'h00);
    @(posedge i_clk) i_special_evt <= 1'b1;
    d = 8'h00;
    for (int k = 0; k < 8 && d === 8'h00; k++) begin
      @(posedge i_clk);
      #1 d = {7'h0, o_timer_clear};
    end
    chk(d, 8'h01, "timer clear");
    @(posedge i_clk) i_special_evt <= 1'b0;
    wait_done(n);
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h0F, "triggered conversion");
    wr(sar_adc_pkg::OFF_FLAGS, 8'h00);
    done_test("special event");
    // sleep on a divided clock aborts and powers down, on bit kept
    wr(sar_adc_pkg::OFF_CTRL_B, 8'h60);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    repeat (100) @(posedge i_clk);
    i_sleep <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1 chk({7'h0, o_analog_on}, 8'h00, "off in sleep");
    chk_rd(sar_adc_pkg::OFF_CTRL_A, 8'h01, "aborted by sleep");
    // sleep on rc: conversion runs, then powers down, on bit kept
    @(posedge i_clk) i_sleep <= 1'b0;
    wr(sar_adc_pkg::OFF_CTRL_B, 8'h30);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    @(posedge i_clk) i_sleep <= 1'b1;
    wait_done(n);
    chk_rd(sar_adc_pkg::OFF_FLAGS, 8'h01, "rc conversion in sleep");
    chk({7'h0, o_analog_on}, 8'h00, "powered down after");
    chk_rd(sar_adc_pkg::OFF_CTRL_A, 8'h01, "on bit kept");
    // enabled completion wakes the device
    wr(sar_adc_pkg::OFF_FLAGS, 8'h02);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    wait_done(n);
    repeat (3) @(posedge i_clk);
    #1 chk({7'h0, o_wake}, 8'h01, "wake");
    chk({7'h0, o_vector}, 8'h00, "no vector after wake");
    done_test("sleep");
    // reset in mid-conversion
    @(posedge i_clk) i_sleep <= 1'b0;
    wr(sar_adc_pkg::OFF_CTRL_B, 8'h60);
    wr(sar_adc_pkg::OFF_CTRL_A, 8'h03);
    repeat (50) @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1 chk({7'h0, o_analog_on}, 8'h00, "off after reset");
    chk_rd(sar_adc_pkg::OFF_CTRL_A, sar_adc_pkg::CTRL_A_RST, "control after reset");
    chk_rd(sar_adc_pkg::OFF_RESULT, sar_adc_pkg::RESULT_RST, "result after reset");
    done_test("reset in conversion");
    report_and_stop();
  end
endmodule
